/* lvgs_defs.vh */
// Constants for the legacy video general control and status register decoder
`ifndef LVGS_DEFS_VH
`define LVGS_DEFS_VH
// ----------------------------------------------------------------
// Register addresses (I/O address equals memory offset)
// ----------------------------------------------------------------
`define LVGS_ADDR_STATUS_ONE_MONO   16'h03BA
`define LVGS_ADDR_STATUS_ONE_COLOR  16'h03DA
`define LVGS_ADDR_STATUS_ZERO       16'h03C2
`define LVGS_ADDR_MISC_WRITE        16'h03C2
`define LVGS_ADDR_FEATURE_READ      16'h03CA
`define LVGS_ADDR_MISC_READ         16'h03CC
`define LVGS_ADDR_STATUS_ONE_HIGH   16'h03DB
`define LVGS_ADDR_STATUS_ONE_HIGH_M 16'h03BB
// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define LVGS_MISC_IOSEL_BIT    0
`define LVGS_MISC_CLKSEL_LO    2
`define LVGS_MISC_CLKSEL_HI    3
`define LVGS_MISC_WMASK        8'hEF
`define LVGS_FEAT_WMASK        8'h08
`define LVGS_ST0_SENSE_BIT     4
`define LVGS_ST1_VSYNC_BIT     3
`define LVGS_ST1_BLANK_BIT     0
// ----------------------------------------------------------------
// Reset values and access answers
// ----------------------------------------------------------------
`define LVGS_MISC_RESET        8'h00
`define LVGS_FEAT_RESET        8'h00
`define LVGS_DWORD_READ_VALUE  32'hFFFF_FFFF
`define LVGS_MMIO_SPAN         32'h0000_1000
// ----------------------------------------------------------------
// Access sizes
// ----------------------------------------------------------------
`define LVGS_SIZE_BYTE         2'h0
`define LVGS_SIZE_WORD         2'h1
`define LVGS_SIZE_DWORD        2'h2
`endif

/* lvgs_regs.v */
// Legacy video general control and status register decoder
`timescale 1ns/1ns
`include "lvgs_defs.vh"
// What this block does
// - Accept byte, aligned word and doubleword accesses
// - Doubleword writes are dropped entirely
// - Doubleword reads return all ones
// - Registers also answer at memory base offsets
// - Extended graphics reached by indexes, not addresses
// - Four registers addressed directly, no index
// - Misc read 3CC, write 3C2; 3C2 reads status0
// - Feature read 3CA, written at status1 address
// - Status1 address follows mono/colour select
// - Status0 read-only, reserved bits read zero
// - Retrace interrupt pending bit reads zero
// - Status0 bit 4 shows comparator sense
// - Blank bit set during either retrace
// - Horizontal retrace covers porches and sync
// - Vertical retrace covers all non-active lines
// - Native mode uses 25/28 MHz dot clock select
// - Status1 bit 3 shows legacy vertical sync
// - Status1 bit 0 low only during active video
module lvgs_regs (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        busReq,
  input  wire        busWrite,
  input  wire        busMemSpace,
  input  wire [31:0] busAddr,
  input  wire [1:0]  busSize,
  input  wire [31:0] busWdata,
  input  wire [31:0] mmioBaseAddress,
  input  wire        cmpSense,
  input  wire        hRetrace,
  input  wire        vRetrace,
  input  wire        vSync,
  output reg         busAck,
  output reg         busHit,
  output reg         busErr,
  output reg  [31:0] busRdata,
  output reg  [7:0]  miscellaneousOutput,
  output reg  [7:0]  featureControl,
  output reg  [1:0]  dotClockSel,
  output reg         colorEmulation
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins come from the display and comparator domains; second and
  // third stages must agree before a change is taken.
  reg [3:0] syncA_r;
  reg [3:0] syncB_r;
  reg [3:0] syncC_r;
  reg [3:0] stable_r;
  wire [3:0] rawIn = {vSync, vRetrace, hRetrace, cmpSense};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gSync
      always @(posedge clk) begin
        if (sys_rst) begin
          syncA_r[g]  <= 1'b0;
          syncB_r[g]  <= 1'b0;
          syncC_r[g]  <= 1'b0;
          stable_r[g] <= 1'b0;
        end else begin
          syncA_r[g] <= rawIn[g];
          syncB_r[g] <= syncA_r[g];
          syncC_r[g] <= syncB_r[g];
          if (syncB_r[g] == syncC_r[g]) begin
            stable_r[g] <= syncC_r[g];
          end
        end
      end
    end
  endgenerate

  wire senseNow  = stable_r[0];
  wire hRetNow   = stable_r[1];
  wire vRetNow   = stable_r[2];
  wire vSyncNow  = stable_r[3];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Memory accesses are rebased to the I/O address; both spaces then
  // share one decoder.
  function [15:0] localAddr;
    input        memSpace;
    input [31:0] addr;
    input [31:0] base;
    reg   [31:0] diff;
    begin
      diff = addr - base;
      if (memSpace) begin
        localAddr = (diff < `LVGS_MMIO_SPAN) ? diff[15:0] : 16'hFFFF;
      end else begin
        localAddr = addr[15:0];
      end
    end
  endfunction

  // True when the byte address lies in the requested lane set
  function covers;
    input [15:0] start;
    input [1:0]  size;
    input [15:0] target;
    begin
      if (size == `LVGS_SIZE_WORD) begin
        covers = (target == start) || (target == start + 16'h0001);
      end else begin
        covers = (target == start);
      end
    end
  endfunction

  wire [15:0] la = localAddr(busMemSpace, busAddr, mmioBaseAddress);
  wire isDword = (busSize == `LVGS_SIZE_DWORD);
  wire isWord  = (busSize == `LVGS_SIZE_WORD);
  wire sizeOk  = (busSize == `LVGS_SIZE_BYTE) || (isWord && !la[0]);

  // Only the alias of the selected emulation answers.
  wire [15:0] st1Addr = miscellaneousOutput[`LVGS_MISC_IOSEL_BIT] ?
                        `LVGS_ADDR_STATUS_ONE_COLOR : `LVGS_ADDR_STATUS_ONE_MONO;

  // Direct decode, no index step; no address beyond the legacy set is
  // decoded, so extended registers stay behind the existing index ports.
  wire hitSt0  = covers(la, busSize, `LVGS_ADDR_STATUS_ZERO);
  wire hitSt1  = covers(la, busSize, st1Addr);
  wire hitFcrR = covers(la, busSize, `LVGS_ADDR_FEATURE_READ);
  wire hitMscR = covers(la, busSize, `LVGS_ADDR_MISC_READ);
  wire hitMscW = covers(la, busSize, `LVGS_ADDR_MISC_WRITE);
  wire hitFcrW = covers(la, busSize, st1Addr);
  wire anyRd   = hitSt0 | hitSt1 | hitFcrR | hitMscR;
  wire anyWr   = hitMscW | hitFcrW;
  wire dwHit   = (la[15:2] == `LVGS_ADDR_STATUS_ZERO >> 2) |
                 (la[15:2] == `LVGS_ADDR_FEATURE_READ >> 2) |
                 (la[15:2] == `LVGS_ADDR_MISC_READ >> 2) |
                 (la[15:2] == st1Addr >> 2);

  // ----------------------------------------------------------------
  // Status images
  // ----------------------------------------------------------------
  // Interrupt pending and reserved bits are constant zero.
  wire [7:0] st0Val = {3'b000, senseNow, 4'b0000};
  // Blanking is the OR of both retrace intervals; the retrace inputs
  // already span porches and sync.
  wire [7:0] st1Val = {4'b0000, vSyncNow, 2'b00, hRetNow | vRetNow};

  function [7:0] laneByte;
    input [15:0] target;
    input [15:0] start;
    input [7:0]  value;
    input        hit;
    begin
      laneByte = 8'h00;
      if (hit && (target == start)) begin
        laneByte = value;
      end
    end
  endfunction

  reg [7:0] byte0;
  reg [7:0] byte1;
  always @* begin
    byte0 = laneByte(la, `LVGS_ADDR_STATUS_ZERO, st0Val, hitSt0) |
            laneByte(la, st1Addr, st1Val, hitSt1) |
            laneByte(la, `LVGS_ADDR_FEATURE_READ, featureControl, hitFcrR) |
            laneByte(la, `LVGS_ADDR_MISC_READ, miscellaneousOutput, hitMscR);
    byte1 = laneByte(la, `LVGS_ADDR_STATUS_ZERO + 16'h0001, st0Val, hitSt0) |
            laneByte(la, st1Addr + 16'h0001, st1Val, hitSt1) |
            laneByte(la, `LVGS_ADDR_FEATURE_READ + 16'h0001, featureControl, hitFcrR) |
            laneByte(la, `LVGS_ADDR_MISC_READ + 16'h0001, miscellaneousOutput, hitMscR);
    // Byte lane of the word that holds the register
    if (isWord && (la + 16'h0001 == `LVGS_ADDR_STATUS_ZERO ||
                   la + 16'h0001 == st1Addr ||
                   la + 16'h0001 == `LVGS_ADDR_FEATURE_READ ||
                   la + 16'h0001 == `LVGS_ADDR_MISC_READ)) begin
      byte1 = byte0 | byte1;
      byte0 = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Write data selection
  // ----------------------------------------------------------------
  function [7:0] pickLane;
    input [15:0] start;
    input [15:0] target;
    input [31:0] data;
    begin
      pickLane = (target == start) ? data[7:0] : data[15:8];
    end
  endfunction

  wire [7:0] mscWData = pickLane(la, `LVGS_ADDR_MISC_WRITE, busWdata);
  wire [7:0] fcrWData = pickLane(la, st1Addr, busWdata);

  // ----------------------------------------------------------------
  // Registers and bus answer
  // ----------------------------------------------------------------
  // Every request answers one cycle later; refused sizes show on busErr.
  always @(posedge clk) begin
    if (sys_rst) begin
      busAck              <= 1'b0;
      busHit              <= 1'b0;
      busErr              <= 1'b0;
      busRdata            <= 32'h0000_0000;
      miscellaneousOutput <= `LVGS_MISC_RESET;
      featureControl      <= `LVGS_FEAT_RESET;
      dotClockSel         <= 2'b00;
      colorEmulation      <= 1'b0;
    end else begin
      busAck   <= busReq;
      busHit   <= 1'b0;
      busErr   <= 1'b0;
      busRdata <= 32'h0000_0000;
      if (busReq) begin
        if (isDword) begin
          // Doubleword writes change nothing.
          busHit <= dwHit;
          if (!busWrite) begin
            busRdata <= `LVGS_DWORD_READ_VALUE;
          end
        end else if (!sizeOk) begin
          busErr <= 1'b1;
        end else if (busWrite) begin
          busHit <= anyWr;
          if (hitMscW) begin
            miscellaneousOutput <= mscWData & `LVGS_MISC_WMASK;
            dotClockSel <= mscWData[`LVGS_MISC_CLKSEL_HI:`LVGS_MISC_CLKSEL_LO];
            colorEmulation <= mscWData[`LVGS_MISC_IOSEL_BIT];
          end
          if (hitFcrW) begin
            featureControl <= fcrWData & `LVGS_FEAT_WMASK;
          end
        end else begin
          busHit   <= anyRd;
          busRdata <= {16'h0000, byte1, byte0};
        end
      end
    end
  end

endmodule

/* lvgs_regs_sva.sv */
// Checker for the legacy video status register decoder
`timescale 1ns/1ns
module lvgs_regs_sva (
  input wire        clk,
  input wire        sys_rst,
  input wire        busReq,
  input wire        busWrite,
  input wire        busMemSpace,
  input wire [31:0] busAddr,
  input wire [1:0]  busSize,
  input wire [31:0] busWdata,
  input wire        busAck,
  input wire        busHit,
  input wire        busErr,
  input wire [31:0] busRdata,
  input wire [7:0]  miscellaneousOutput,
  input wire [7:0]  featureControl,
  input wire [1:0]  dotClockSel,
  input wire        colorEmulation
);
  wire        ioRead  = busReq & ~busWrite & ~busMemSpace;
  wire        ioWrite = busReq & busWrite & ~busMemSpace;
  wire [15:0] lowAddr = busAddr[15:0];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ack_timing_a: assert property (
    busAck == $past(busReq)) else $error("ack not one cycle after request");
  odd_word_err_a: assert property (
    busReq && busSize == 2'h1 && busAddr[0] |=> busErr && $stable(miscellaneousOutput))
    else $error("odd word access not refused");
  dword_write_drop_a: assert property (
    busReq && busWrite && busSize == 2'h2 |=> $stable(miscellaneousOutput) && $stable(featureControl))
    else $error("doubleword write changed a register");
  dword_read_ones_a: assert property (
    ioRead && busSize == 2'h2 && lowAddr == 16'h03CC |=> busRdata == 32'hFFFF_FFFF)
    else $error("doubleword read not all ones");
  status_zero_rsvd_a: assert property (
    ioRead && busSize == 2'h0 && lowAddr == 16'h03C2 |=> (busRdata[7:0] & 8'hEF) == 8'h00)
    else $error("status zero reserved bits set");
  misc_write_a: assert property (
    ioWrite && busSize == 2'h0 && lowAddr == 16'h03C2
    |=> {24'h00_0000, miscellaneousOutput} == ($past(busWdata) & 32'h0000_00EF))
    else $error("misc write lost");
  mode_track_a: assert property (
    dotClockSel == miscellaneousOutput[3:2] && colorEmulation == miscellaneousOutput[0])
    else $error("mode outputs differ from misc");
  wrong_alias_a: assert property (
    ioRead && busSize == 2'h0 && lowAddr == (colorEmulation ? 16'h03BA : 16'h03DA)
    |=> !busHit && busRdata == 32'h0000_0000) else $error("unselected alias answered");
  feat_write_a: assert property (
    ioWrite && busSize == 2'h0 && lowAddr == (colorEmulation ? 16'h03DA : 16'h03BA)
    |=> {24'h00_0000, featureControl} == ($past(busWdata) & 32'h0000_0008))
    else $error("feature write lost");
endmodule
bind lvgs_regs lvgs_regs_sva u_sva (.clk(clk), .sys_rst(sys_rst), .busReq(busReq),
  .busWrite(busWrite), .busMemSpace(busMemSpace), .busAddr(busAddr), .busSize(busSize),
  .busWdata(busWdata), .busAck(busAck), .busHit(busHit), .busErr(busErr), .busRdata(busRdata),
  .miscellaneousOutput(miscellaneousOutput), .featureControl(featureControl),
  .dotClockSel(dotClockSel), .colorEmulation(colorEmulation));

/* lvgs_host.sv */
// Host processor model issuing legacy I/O and memory accesses
`timescale 1ns/1ns
module lvgs_host (
  input  wire        clk,
  input  wire [31:0] mmioBaseAddress,
  input  wire        busAck,
  input  wire        busHit,
  input  wire        busErr,
  input  wire [31:0] busRdata,
  output reg         busReq = 1'b0,
  output reg         busWrite = 1'b0,
  output reg         busMemSpace = 1'b0,
  output reg  [31:0] busAddr = 32'h0000_0000,
  output reg  [1:0]  busSize = 2'h0,
  output reg  [31:0] busWdata = 32'h0000_0000
);
  // Touches no display plane; extended graphics are never reached in memory
  task xfer(input w, input m, input [15:0] off, input [1:0] sz, input [31:0] wd,
            output [31:0] rd, output hit, output err, output ok);
    begin
      @(posedge clk);
      #1;
      busReq = 1'b1;
      busWrite = w;
      busMemSpace = m;
      busAddr = m ? mmioBaseAddress + {16'h0000, off} : {16'h0000, off};
      busSize = sz;
      busWdata = wd; // Callers keep words even except on purpose
      @(posedge clk);
      #1;
      busReq = 1'b0;
      // Released lines must not keep a plausible value
      {busWrite, busAddr, busSize, busWdata} = ~{busWrite, busAddr, busSize, busWdata};
      ok = (busAck === 1'b1);
      rd = busRdata;
      hit = busHit;
      err = busErr;
    end
  endtask
endmodule

/* lvgs_regs_bench.sv */
// Self-checking bench for the legacy video status register decoder
`timescale 1ns/1ns
module lvgs_regs_bench;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [31:0] mmioBaseAddress = 32'h0000_0000;
  reg  [3:0]  pins = 4'h0;
  wire        busReq, busWrite, busMemSpace, busAck, busHit, busErr, colorEmulation;
  wire [31:0] busAddr, busWdata, busRdata;
  wire [1:0]  busSize, dotClockSel;
  wire [7:0]  miscellaneousOutput, featureControl;
  reg  [31:0] rd, v, f;
  reg         hit, err, ok;
  integer     seed = 63, errorCnt = 0, testsRun = 0, i;
  always #25 clk = ~clk;
  lvgs_regs u_dut (.clk(clk), .sys_rst(sys_rst), .busReq(busReq), .busWrite(busWrite),
    .busMemSpace(busMemSpace), .busAddr(busAddr), .busSize(busSize), .busWdata(busWdata),
    .mmioBaseAddress(mmioBaseAddress), .cmpSense(pins[0]), .hRetrace(pins[1]),
    .vRetrace(pins[2]), .vSync(pins[3]), .busAck(busAck), .busHit(busHit), .busErr(busErr),
    .busRdata(busRdata), .miscellaneousOutput(miscellaneousOutput),
    .featureControl(featureControl), .dotClockSel(dotClockSel), .colorEmulation(colorEmulation));
  lvgs_host u_host (.clk(clk), .mmioBaseAddress(mmioBaseAddress), .busAck(busAck),
    .busHit(busHit), .busErr(busErr), .busRdata(busRdata), .busReq(busReq),
    .busWrite(busWrite), .busMemSpace(busMemSpace), .busAddr(busAddr), .busSize(busSize),
    .busWdata(busWdata));
  function [31:0] st0(input [3:0] p);
    st0 = {27'h000_0000, p[0], 4'h0};
  endfunction
  function [31:0] st1(input [3:0] p);
    st1 = {28'h000_0000, p[3], 2'h0, p[1] | p[2]};
  endfunction
  task completeRun;
    begin
      if (errorCnt == 0 && testsRun > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      testsRun = testsRun + 1;
      if (got !== exp) begin
        $display("MISMATCH %0s exp %h got %h", nm, exp, got);
        errorCnt = errorCnt + 1;
      end
    end
  endtask
  // A missing answer ends the run at once
  task acc(input w, input m, input [15:0] a, input [1:0] sz, input [31:0] wd);
    begin
      u_host.xfer(w, m, a, sz, wd, rd, hit, err, ok);
      if (ok !== 1'b1) begin
        errorCnt = errorCnt + 1;
        completeRun;
      end
    end
  endtask
  initial begin
    v = $random(seed);
    mmioBaseAddress = {v[31:12], 12'h000};
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    acc(1'b0, 1'b0, 16'h03CC, 2'h0, 32'h0000_0000);
    chk("misc", 32'h0000_0000, rd);
    for (i = 0; i < 12; i = i + 1) begin
      v = $random(seed) & 32'h0000_00FF;
      f = $random(seed) & 32'h0000_00FF;
      acc(1'b1, i[0], 16'h03C2, {1'b0, i[1]}, v);
      acc(1'b0, !i[0], 16'h03CC, 2'h0, 32'h0000_0000);
      chk("misc", v & 32'h0000_00EF, rd);
      chk("mode", {29'h0, v[3:2], v[0]}, {29'h0, dotClockSel, colorEmulation});
      acc(1'b1, 1'b0, v[0] ? 16'h03DA : 16'h03BA, 2'h0, f);
      acc(1'b1, 1'b0, v[0] ? 16'h03BA : 16'h03DA, 2'h0, ~f);
      acc(1'b0, i[1], 16'h03CA, 2'h0, 32'h0000_0000);
      chk("feat", f & 32'h0000_0008, rd);
      acc(1'b0, 1'b0, v[0] ? 16'h03BA : 16'h03DA, 2'h0, 32'h0000_0000);
      chk("alias", 32'h0000_0000, {rd[30:0], hit});
      acc(1'b1, 1'b0, 16'h03C2, 2'h2, ~v);
      acc(1'b1, 1'b0, 16'h03C3, 2'h1, ~v);
      chk("err", 32'h0000_0001, {31'h0, err});
      acc(1'b0, 1'b0, 16'h03CC, 2'h2, 32'h0000_0000);
      chk("dword", 32'hFFFF_FFFF, rd);
      acc(1'b0, 1'b0, 16'h03CC, 2'h1, 32'h0000_0000);
      chk("word", v & 32'h0000_00EF, rd & 32'h0000_00FF);
    end
    for (i = 0; i < 16; i = i + 1) begin
      pins = i[3:0];
      // Status pins are synchronised, so let them settle first
      repeat (6) @(posedge clk);
      acc(1'b0, i[2], 16'h03C2, 2'h0, 32'h0000_0000);
      chk("st0", st0(pins), rd);
      acc(1'b0, i[0], v[0] ? 16'h03DA : 16'h03BA, 2'h0, 32'h0000_0000);
      chk("st1", st1(pins), rd);
    end
    completeRun;
  end
endmodule
